// File: design/sfc_pkg.sv
// package: register map, field positions and constants of the spi control slice
package sfc_pkg;
	localparam int          ADDR_W       = 12;
	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_TX      = 12'h004;
	localparam logic [11:0] ADDR_RX      = 12'h008;
	localparam logic [11:0] ADDR_STAT    = 12'h00c;
	localparam int          CLK_DIS      = 12;
	localparam int          DATA_DIS     = 11;
	localparam int          WIDE_SEL     = 10;
	localparam int          SAMPLE_END   = 9;
	localparam int          EDGE_SEL     = 8;
	localparam int          SEL_EN       = 7;
	localparam int          IDLE_POL     = 6;
	localparam int          MASTER_EN    = 5;
	localparam logic [15:0] CTRL_WMASK   = 16'h1fe0;
	localparam logic [15:0] CTRL_RESET   = 16'h0000;
	localparam logic [4:0]  BYTE_BITS    = 5'h08;
	localparam logic [4:0]  WORD_BITS    = 5'h10;
	localparam int          STAT_BUSY    = 0;
	localparam int          STAT_DONE    = 1;
	localparam logic [5:0]  FIRST_END_K  = 6'h02;
	localparam int          HALF_DEFAULT = 2;
	typedef enum logic {MST_IDLE, MST_RUN} sfc_mst_type;
endpackage

// File: design/sfc_link_if.sv
// signals between the control side and the link-clock slave engine
`timescale 1ns/1ps
interface sfc_link_if;
	logic [15:0] txWord;
	logic        wide;
	logic        changeLead;
	logic        outOnRise;
	logic        ssIdle;
	logic [15:0] rxWord;
	logic        doneTgl;
	logic        outBit;
	modport ctl (
		output txWord, wide, changeLead, outOnRise, ssIdle,
		input  rxWord, doneTgl, outBit
	);
	modport eng (
		input  txWord, wide, changeLead, outOnRise, ssIdle,
		output rxWord, doneTgl, outBit
	);
endinterface

// File: design/sfc_sync.sv
// two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
module sfc_sync #(
	parameter int W = 1
) (
	// clock, reset and enable
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         ce,
	// levels
	input  wire logic [W-1:0] din,
	output      logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] held;
	} sfc_sync_type;

	sfc_sync_type st;
	sfc_sync_type next_st;

	always_comb
	begin
		next_st = st;
		if (ce)
		begin
			next_st.meta = din;
			next_st.held = st.meta;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign dout = st.held;
endmodule

// File: design/sfc_link_slave.sv
// slave shift engine clocked by the serial clock of the far master
`timescale 1ns/1ps
module sfc_link_slave (
	// link clock and reset
	input wire logic serialClockIn,
	input wire logic arst_n,
	// serial data from the far master
	input wire logic serialDataIn,
	// control side
	sfc_link_if.eng  lnk
);
	typedef struct packed {
		logic [15:0] rxs;
		logic [4:0]  cnt;
		logic [15:0] rxWord;
		logic        tgl;
	} sfc_rise_type;
	typedef struct packed {
		logic [4:0] idx;
		logic       started;
	} sfc_fall_type;

	sfc_rise_type rs;
	sfc_rise_type next_rs;
	sfc_fall_type fs;
	sfc_fall_type next_fs;
	logic         inFrame;
	logic [4:0]   bits;
	logic [4:0]   cntNow;
	logic [15:0]  rxNew;
	logic         dclk;
	logic         linkRst_n;

	assign bits = lnk.wide ? sfc_pkg::WORD_BITS : sfc_pkg::BYTE_BITS;
	// sample on rising dclk, change data on falling dclk
	assign dclk = serialClockIn ^ lnk.outOnRise;
	// a deasserted select holds the frame logic cleared
	assign linkRst_n = arst_n & ~lnk.ssIdle;
	assign cntNow = inFrame ? rs.cnt : '0;

	// sample phase bit not used here: slave samples mid-bit
	always_comb
	begin
		next_rs = rs;
		rxNew = {rs.rxs[14:0], serialDataIn};
		next_rs.rxs = rxNew;
		next_rs.cnt = cntNow + 5'h01;
		if (next_rs.cnt == bits)
		begin
			next_rs.cnt = '0;
			next_rs.rxWord = lnk.wide ? rxNew : {8'h00, rxNew[7:0]};
			next_rs.tgl = ~rs.tgl;
		end
	end

	always_comb
	begin
		next_fs = fs;
		if (lnk.changeLead && !fs.started)
			next_fs.started = 1'b1;
		else if (fs.idx + 5'h01 == bits)
			next_fs.idx = '0;
		else
			next_fs.idx = fs.idx + 5'h01;
	end

	always_ff @(posedge dclk or negedge arst_n)
	begin
		if (!arst_n)
			rs <= '0;
		else
			rs <= next_rs;
	end

	always_ff @(posedge dclk or negedge linkRst_n)
	begin
		if (!linkRst_n)
			inFrame <= 1'b0;
		else
			inFrame <= 1'b1;
	end

	always_ff @(negedge dclk or negedge linkRst_n)
	begin
		if (!linkRst_n)
			fs <= '0;
		else
			fs <= next_fs;
	end

	assign lnk.rxWord = rs.rxWord;
	assign lnk.doneTgl = rs.tgl;
	// data held inactive while not selected
	assign lnk.outBit = lnk.ssIdle ? 1'b0 :
		lnk.txWord[4'(bits - 5'h01 - fs.idx)];
endmodule

// File: design/sfc_frame_ctrl.sv
// spi frame format control: apb registers, master engine and pin control
//
// Operation
// - in master mode a set clock disable bit releases the clock pin.
// - a set data disable bit releases the data output pin.
// - a set width bit shifts 16-bit words, a clear one 8-bit bytes.
// - master with sample bit set samples input at the bit period end.
// - master with sample bit clear samples input mid bit period.
// - edge bit set changes output on the active-to-idle clock edge.
// - edge bit clear changes output on the idle-to-active clock edge.
// - slave with select enable set uses the select pin for transfers.
// - select enable clear ignores the select pin.
// - polarity bit set idles the clock high, clear idles it low.
`timescale 1ns/1ps
module sfc_frame_ctrl #(
	parameter int HALF = sfc_pkg::HALF_DEFAULT
) (
	// system clock, reset and clock enable
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	// serial clock pin
	input  wire logic        serialClockIn,
	output      logic        serialClockOut,
	output      logic        serialClockOeN,
	// serial data pins
	input  wire logic        serialDataIn,
	output      logic        serialDataOut,
	output      logic        serialDataOeN,
	// slave select pin
	input  wire logic        slaveSelectIn
);
	typedef struct packed {
		logic [15:0]          ctrl;
		logic [15:0]          tx;
		logic [15:0]          rx;
		logic                 done;
		logic                 tglSeen;
		sfc_pkg::sfc_mst_type mst;
		logic [15:0]          div;
		logic [5:0]           k;
		logic [15:0]          sh;
		logic [15:0]          rxs;
		logic [4:0]           nSamp;
		logic [1:0]           pend;
		logic                 sck;
		logic                 sckOeN;
		logic                 sdo;
		logic                 sdoOeN;
		logic [31:0]          prdata;
		logic                 pready;
		logic                 pslverr;
	} sfc_state_type;

	localparam logic [15:0] HALF_LAST = 16'(HALF - 1);
	localparam sfc_state_type STATE_RESET = '{
		ctrl: sfc_pkg::CTRL_RESET,
		mst: sfc_pkg::MST_IDLE,
		sckOeN: 1'b1,
		sdoOeN: 1'b1,
		default: '0
	};

	sfc_state_type st;
	sfc_state_type next_st;

	logic        isMaster;
	logic        clkDis;
	logic        dataDis;
	logic        wide;
	logic        sampleEnd;
	logic        changeTrail;
	logic        selEn;
	logic        idlePol;
	logic [4:0]  bits;
	logic [5:0]  endK;
	logic [2:0]  syncOut;
	logic        sdiS;
	logic        ssS;
	logic        tglS;
	logic [5:0]  kk;
	logic        outEdge;
	logic        sampleNow;
	logic        start;
	logic [15:0] load;
	logic [15:0] rxFinal;

	sfc_link_if lnk ();

	assign isMaster    = st.ctrl[sfc_pkg::MASTER_EN];
	assign clkDis      = st.ctrl[sfc_pkg::CLK_DIS];
	assign dataDis     = st.ctrl[sfc_pkg::DATA_DIS];
	assign wide        = st.ctrl[sfc_pkg::WIDE_SEL];
	assign sampleEnd   = st.ctrl[sfc_pkg::SAMPLE_END];
	assign changeTrail = st.ctrl[sfc_pkg::EDGE_SEL];
	assign selEn       = st.ctrl[sfc_pkg::SEL_EN];
	assign idlePol     = st.ctrl[sfc_pkg::IDLE_POL];
	assign bits = wide ? sfc_pkg::WORD_BITS : sfc_pkg::BYTE_BITS;
	assign endK = {bits, 1'b1};

	// pin and cross-domain synchronisers
	sfc_sync #(
		.W(3)
	) u_sync (
		.clk    (mclk),
		.arst_n (arst_n),
		.ce     (ce),
		.din    ({lnk.doneTgl, slaveSelectIn, serialDataIn}),
		.dout   (syncOut)
	);
	assign sdiS = syncOut[0];
	assign ssS  = syncOut[1];
	assign tglS = syncOut[2];

	// slave engine on the link clock
	sfc_link_slave u_slave (
		.serialClockIn (serialClockIn),
		.arst_n        (arst_n),
		.serialDataIn  (serialDataIn),
		.lnk           (lnk)
	);
	assign lnk.txWord     = st.tx;
	assign lnk.wide       = wide;
	assign lnk.changeLead = ~changeTrail;
	assign lnk.outOnRise  = (idlePol == changeTrail);
	assign lnk.ssIdle = ~isMaster & selEn & slaveSelectIn;

	always_comb
	begin
		next_st = st;
		kk = st.k + 6'h01;
		outEdge = 1'b0;
		sampleNow = 1'b0;
		start = 1'b0;
		load = wide ? pwdata[15:0] : {pwdata[7:0], 8'h00};
		rxFinal = st.rxs;
		if (ce)
		begin
			next_st.pready = 1'b0;
			next_st.pslverr = 1'b0;
			// setup phase prepares the answer for the access phase
			if (psel && !penable)
			begin
				next_st.pready = 1'b1;
				next_st.prdata = '0;
				case (paddr)
				sfc_pkg::ADDR_CTRL:
					next_st.prdata = {16'h0000, st.ctrl};
				sfc_pkg::ADDR_TX:
					next_st.prdata = {16'h0000, st.tx};
				sfc_pkg::ADDR_RX:
					next_st.prdata = {16'h0000, st.rx};
				sfc_pkg::ADDR_STAT:
				begin
					next_st.prdata[sfc_pkg::STAT_BUSY] =
						(st.mst == sfc_pkg::MST_RUN);
					next_st.prdata[sfc_pkg::STAT_DONE] = st.done;
				end
				default:
					next_st.pslverr = 1'b1;
				endcase
			end
			// access phase: writes and read side effects
			if (psel && penable && st.pready && !st.pslverr)
			begin
				if (pwrite && paddr == sfc_pkg::ADDR_CTRL)
					next_st.ctrl = pwdata[15:0] & sfc_pkg::CTRL_WMASK;
				if (pwrite && paddr == sfc_pkg::ADDR_TX)
				begin
					next_st.tx = pwdata[15:0];
					start = isMaster && (st.mst == sfc_pkg::MST_IDLE);
				end
				if (!pwrite && paddr == sfc_pkg::ADDR_RX)
					next_st.done = 1'b0;
			end
			// master engine
			unique case (st.mst)
			sfc_pkg::MST_IDLE:
			begin
				next_st.sck = idlePol;
				if (start)
				begin
					next_st.mst = sfc_pkg::MST_RUN;
					next_st.div = '0;
					next_st.k = '0;
					next_st.nSamp = '0;
					next_st.rxs = '0;
					if (changeTrail)
					begin
						next_st.sdo = load[15];
						next_st.sh = {load[14:0], 1'b0};
					end
					else
						next_st.sh = load;
				end
			end
			sfc_pkg::MST_RUN:
			begin
				next_st.div = st.div + 16'h0001;
				if (st.div == HALF_LAST)
				begin
					next_st.div = '0;
					next_st.k = kk;
					if (kk < endK)
						next_st.sck = ~st.sck;
					outEdge = changeTrail ?
						(!kk[0] && kk < endK - 6'h01) :
						(kk[0] && kk < endK);
					sampleNow = (kk[0] == (changeTrail ^ sampleEnd))
						&& (kk >= sfc_pkg::FIRST_END_K
						|| (changeTrail && !sampleEnd))
						&& st.nSamp != bits;
					if (outEdge)
					begin
						next_st.sdo = st.sh[15];
						next_st.sh = {st.sh[14:0], 1'b0};
					end
					if (sampleNow)
						next_st.nSamp = st.nSamp + 5'h01;
				end
			end
			endcase
			// the synchroniser lags the pin by two cycles, so a
			// sample lands two cycles after its edge
			next_st.pend = {st.pend[0], sampleNow};
			if (st.pend[1])
			begin
				rxFinal = {st.rxs[14:0], sdiS};
				next_st.rxs = rxFinal;
			end
			// finish once the last sample has landed
			if (st.mst == sfc_pkg::MST_RUN && st.k >= endK
				&& !st.pend[0])
			begin
				next_st.mst = sfc_pkg::MST_IDLE;
				next_st.rx = wide ? rxFinal : {8'h00, rxFinal[7:0]};
				next_st.done = 1'b1;
			end
			// slave word arrival, set wins over the read clear
			next_st.tglSeen = tglS;
			if (tglS != st.tglSeen && !isMaster)
			begin
				next_st.rx = lnk.rxWord;
				next_st.done = 1'b1;
			end
			// pin ownership
			next_st.sckOeN = !(isMaster && !clkDis);
			next_st.sdoOeN = dataDis
				|| (!isMaster && selEn && ssS);
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			st <= STATE_RESET;
		else
			st <= next_st;
	end

	assign prdata         = st.prdata;
	assign pready         = st.pready;
	assign pslverr        = st.pslverr;
	assign serialClockOut = st.sck;
	assign serialClockOeN = st.sckOeN;
	assign serialDataOut  = isMaster ? st.sdo : lnk.outBit;
	assign serialDataOeN  = st.sdoOeN;

	a_sck_release: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ce && isMaster && clkDis |=> serialClockOeN)
		else $error("clock pin driven while disabled");

	a_sck_driven: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ce && isMaster && !clkDis |=> !serialClockOeN)
		else $error("clock pin not driven in master mode");

	a_sdo_release: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ce && dataDis |=> serialDataOeN)
		else $error("data pin driven while disabled");

	a_width_count: assert property (
		@(posedge mclk) disable iff (!arst_n)
		st.mst == sfc_pkg::MST_RUN ##1 st.mst == sfc_pkg::MST_IDLE
		|-> st.nSamp == $past(bits) && st.k >= $past(endK))
		else $error("wrong number of bits sampled");

	a_sample_end: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ce && sampleNow && sampleEnd
		|-> (kk[0] != changeTrail) && kk >= sfc_pkg::FIRST_END_K)
		else $error("end sample not at period end");

	a_sample_mid: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ce && sampleNow && !sampleEnd
		|-> (kk[0] == changeTrail) && kk < endK)
		else $error("mid sample not at period middle");

	a_trail_change: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ce && outEdge && changeTrail
		|=> serialClockOut == $past(idlePol))
		else $error("data changed off the trailing edge");

	a_lead_change: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ce && outEdge && !changeTrail
		|=> serialClockOut != $past(idlePol))
		else $error("data changed off the leading edge");

	a_idle_level: assert property (
		@(posedge mclk) disable iff (!arst_n)
		(ce && st.mst == sfc_pkg::MST_IDLE)
		##1 (ce && st.mst == sfc_pkg::MST_IDLE)
		|-> serialClockOut == $past(idlePol))
		else $error("idle clock level wrong");

	a_select_off: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ce && !isMaster && selEn && ssS |=> serialDataOeN)
		else $error("data driven while deselected");

	a_select_ignored: assert property (
		@(posedge mclk) disable iff (!arst_n)
		ce && !isMaster && !selEn && !dataDis |=> !serialDataOeN)
		else $error("select pin not ignored");

	a_done_sticky: assert property (
		@(posedge mclk) disable iff (!arst_n)
		st.mst == sfc_pkg::MST_RUN ##1 st.mst == sfc_pkg::MST_IDLE
		|-> st.done && st.pend == 2'b00)
		else $error("transfer end not flagged");
endmodule

// File: sim/sfc_far_slave.sv
// far spi slave model answering the block in master mode
`timescale 1ns/1ps
module sfc_far_slave (
	// pins
	input  wire logic        sck,
	input  wire logic        sdo,
	output      logic        sdi,
	// frame setup from the bench
	input  wire logic        clr,
	input  wire logic        pol,
	input  wire logic        edgeSel,
	input  wire logic        wide,
	input  wire logic [15:0] word,
	output      logic [15:0] got
);
	int chg = 0;
	int idx;
	// forget the last frame
	always @(posedge clr)
	begin
		chg = 0;
		got = 16'h0000;
	end
	// sample on the edge opposite the change edge
	always @(sck)
	begin
		if (clr === 1'b0)
		begin
			if (sck === (edgeSel ? ~pol : pol))
				got = {got[14:0], sdo};
			else
				chg = chg + 1;
		end
	end
	// msb first, one bit per change edge; past the frame the line inverts
	always @(chg or word or wide or edgeSel)
	begin
		idx = edgeSel ? chg : chg - 1;
		if (idx < 0)
			idx = 0;
		if (idx >= (wide ? 16 : 8))
			sdi = ~word[0];
		else
			sdi = word[(wide ? 15 : 7) - idx];
	end
endmodule

// File: sim/tb.sv
// self-checking bench of the spi frame format control block
`timescale 1ns/1ps
module tb;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic        ce = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        serialClockOut;
	logic        serialClockOeN;
	logic        serialDataOut;
	logic        serialDataOeN;
	logic        slaveSelectIn = 1'b1;
	logic        tbSck = 1'b0;
	logic        tbSdi = 1'b0;
	logic        linkMode = 1'b0;
	logic        farSdi;
	logic        farClr = 1'b1;
	logic        farPol = 1'b0;
	logic        farEdge = 1'b0;
	logic        farWide = 1'b0;
	logic [15:0] farWord = 16'h0000;
	logic [15:0] farGot;
	logic [31:0] rd;
	logic        er;
	wire  logic  sckPin;
	wire  logic  sdiPin;
	int          fails = 0;
	int          checked = 0;
	int          toggles = 0;

	assign sckPin = (serialClockOeN === 1'b0) ? serialClockOut : tbSck;
	assign sdiPin = linkMode ? tbSdi : farSdi;
	always #50 mclk = ~mclk;
	always @(sckPin) toggles = toggles + 1;

	sfc_frame_ctrl #(.HALF(2)) sfc_frame_ctrl_inst (
		.mclk(mclk), .arst_n(arst_n), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serialClockIn(sckPin),
		.serialClockOut(serialClockOut), .serialClockOeN(serialClockOeN),
		.serialDataIn(sdiPin), .serialDataOut(serialDataOut),
		.serialDataOeN(serialDataOeN), .slaveSelectIn(slaveSelectIn)
	);
	sfc_far_slave sfc_far_slave_inst (
		.sck(sckPin), .sdo(serialDataOut), .sdi(farSdi), .clr(farClr),
		.pol(farPol), .edgeSel(farEdge), .wide(farWide), .word(farWord),
		.got(farGot)
	);

	task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		// wait for the answer; only the watchdog ends a hang
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task link_frame(input logic [7:0] mosi, output logic [7:0] miso);
		#37;
		for (int i = 0; i < 8; i++)
		begin
			#62.5 tbSck = 1'b1;
			tbSdi = mosi[7 - i];
			#62.5 tbSck = 1'b0;
			miso = {miso[6:0], serialDataOut};
		end
	endtask

	task test_regs;
		apb(1'b0, sfc_pkg::ADDR_CTRL, 32'h0);
		check("ctrl reset", rd, {16'h0, sfc_pkg::CTRL_RESET});
		check("clk oe reset", serialClockOeN, 1'b1);
		check("dat oe reset", serialDataOeN, 1'b0);
		apb(1'b1, sfc_pkg::ADDR_CTRL, 32'hffff_ffff);
		apb(1'b0, sfc_pkg::ADDR_CTRL, 32'h0);
		check("ctrl mask", rd, {16'h0, sfc_pkg::CTRL_WMASK});
		check("clk oe off", serialClockOeN, 1'b1);
		check("dat oe off", serialDataOeN, 1'b1);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped", er, 1'b1);
	endtask

	task test_master(input logic [2:0] i);
		logic [15:0] w;
		logic [15:0] t;
		logic [15:0] m;
		logic        pl;
		int          n;
		pl = i[0] ^ i[2];
		m = i[0] ? 16'hffff : 16'h00ff;
		t = 16'hc3a5 ^ {13'h0, i};
		w = 16'h96e1 ^ {9'h0, i, 4'h0};
		farClr <= 1'b1;
		farWord <= w;
		farPol <= pl;
		farEdge <= i[1];
		farWide <= i[0];
		apb(1'b1, sfc_pkg::ADDR_CTRL,
			{19'h0, 2'b00, i[0], i[2], i[1], 1'b0, pl, 1'b1, 5'h00});
		repeat (2) @(posedge mclk);
		check("clk oe on", serialClockOeN, 1'b0);
		check("dat oe on", serialDataOeN, 1'b0);
		farClr <= 1'b0;
		toggles = 0;
		apb(1'b1, sfc_pkg::ADDR_TX, {16'h0, t});
		// a low enable freezes the running frame
		ce <= 1'b0;
		@(posedge mclk);
		n = toggles;
		repeat (6) @(posedge mclk);
		check("ce freeze", toggles, n);
		ce <= 1'b1;
		for (int k = 0; k < 100; k++)
		begin
			apb(1'b0, sfc_pkg::ADDR_STAT, 32'h0);
			if (rd[sfc_pkg::STAT_BUSY] === 1'b0)
				break;
		end
		check("busy", rd[sfc_pkg::STAT_BUSY], 1'b0);
		check("done", rd[sfc_pkg::STAT_DONE], 1'b1);
		check("toggles", toggles, i[0] ? 32 : 16);
		check("idle level", sckPin, pl);
		check("far got", farGot & m, t & m);
		apb(1'b0, sfc_pkg::ADDR_RX, 32'h0);
		check("rx", rd, {16'h0, w & m});
	endtask

	task test_slave;
		logic [7:0] m;
		linkMode <= 1'b1;
		// slave, select used, sample and edge bits clear
		apb(1'b1, sfc_pkg::ADDR_CTRL, 32'h0000_0080);
		apb(1'b1, sfc_pkg::ADDR_TX, 32'h0000_00a5);
		@(posedge mclk);
		slaveSelectIn <= 1'b0;
		@(posedge mclk);
		link_frame(8'h3c, m);
		check("slave out", m, 8'ha5);
		@(posedge mclk);
		slaveSelectIn <= 1'b1;
		repeat (10) @(posedge mclk);
		apb(1'b0, sfc_pkg::ADDR_RX, 32'h0);
		check("slave rx", rd, 32'h3c);
		link_frame(8'hff, m);
		check("desel oe", serialDataOeN, 1'b1);
		repeat (10) @(posedge mclk);
		apb(1'b0, sfc_pkg::ADDR_STAT, 32'h0);
		check("desel done", rd[sfc_pkg::STAT_DONE], 1'b0);
		apb(1'b1, sfc_pkg::ADDR_CTRL, 32'h0);
		link_frame(8'h5a, m);
		repeat (10) @(posedge mclk);
		apb(1'b0, sfc_pkg::ADDR_RX, 32'h0);
		check("nosel rx", rd, 32'h5a);
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		test_regs;
		for (int i = 0; i < 8; i++)
			test_master(i[2:0]);
		test_slave;
		end_sim;
	end

	initial
	begin
		#3000000;
		fails++;
		end_sim;
	end
endmodule
